// ===== logic/pll_cal_pkg.sv
// Constants and types shared by the clock control and calibration block.
package pll_cal_pkg;
	// Word indices; the byte address is four times the index.
	localparam logic [5:0] IDX_FIRST = 6'h00;
	localparam logic [5:0] IDX_THIRD = 6'h02;
	localparam logic [5:0] IDX_FOURTH = 6'h03;
	localparam logic [5:0] IDX_LOCK = 6'h1B;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h1C;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h1D;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h1E;

	// Field positions.
	localparam int OSC_REQ_BIT = 24;
	localparam int PLL_EN_BIT = 18;
	localparam int DIV_LSB = 8;
	localparam int MANUAL_CP_BIT = 6;
	localparam int CP_LSB = 3;
	localparam int DAC_REQ_BIT = 24;
	localparam int SYNC_EN_BIT = 25;
	localparam int LOCK_BIT = 24;
	localparam int OSC_BUSY_BIT = 0;
	localparam int DAC_BUSY_BIT = 1;

	// Writable bits and reset images.
	localparam logic [31:0] FIRST_WMASK = 32'h0100_0000;
	localparam logic [31:0] THIRD_WMASK = 32'h0004_FF78;
	localparam logic [31:0] FOURTH_WMASK = 32'h0300_0000;
	localparam logic [31:0] FIRST_RESET = 32'h0000_0000;
	localparam logic [31:0] THIRD_RESET = 32'h0000_1918;
	localparam logic [31:0] FOURTH_RESET = 32'h0000_0000;

	// Interrupt status bit positions.
	localparam int EV_OSC_DONE = 0;
	localparam int EV_DAC_DONE = 1;
	localparam int EV_LOCK_GAIN = 2;
	localparam int EV_LOCK_LOSS = 3;

	// Timing, in system sample clock periods and sync input periods; charge-pump current step in microamps.
	localparam int DAC_CAL_CYCLES = 469632;
	localparam int OSC_CAL_CYCLES = 1000;
	localparam logic [3:0] SYNC_LAST_EDGE = 4'hF;
	localparam logic [9:0] CP_STEP_UA = 10'h07D;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef enum logic [2:0] {
		DAC_IDLE = 3'b001,
		DAC_BASE = 3'b010,
		DAC_SYNC = 3'b100
	} dac_state_t;

	typedef struct packed {
		logic [19:0] count;
		logic busy;
		logic done;
	} timer_state_t;
endpackage : pll_cal_pkg

// ===== logic/cal_timer.sv
// Down counter that times one calibration run.
`timescale 1ns/10ps
`default_nettype none
module cal_timer (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [19:0] load,
	output logic busy,
	output logic done
);
	import pll_cal_pkg::*;

	timer_state_t st_q;
	timer_state_t st_d;

	// Busy stays high for exactly load cycles; done pulses in the cycle after.
	always_comb
	begin
		st_d = st_q;
		st_d.done = 1'b0;
		if (start)
		begin
			st_d.count = load - 20'h00001;
			st_d.busy = 1'b1;
		end
		else if (st_q.busy)
		begin
			if (st_q.count == 20'h00000)
			begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end
			else
			begin
				st_d.count = st_q.count - 20'h00001;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign busy = st_q.busy;
	assign done = st_q.done;
endmodule : cal_timer
`default_nettype wire

// ===== logic/pll_clock_and_dac_calibration.sv
// Sample clock source, PLL control, oscillator and converter calibration sequencing.
//
// Functional notes
// - Converter calibration lasts 469,632 system sample clock periods.
// - With multichip sync, calibration adds 16 sync input clock periods.
// - PLL enable selects PLL output, else reference drives system clock directly.
// - Oscillator calibration restarts only after its request is cleared and set again.
// - Oscillator calibration picks charge-pump current from the feedback divide value.
// - Feedback divide is eight bits at bits 15 to 8, usable 10 to 255.
// - Fixed divide-by-two in feedback: multiplication is twice the divide value.
// - Manual select bit set: programmed charge-pump code replaces automatic choice.
// - Charge-pump current is (code + 1) times 125 microamps.
// - Lock status bit reads one while the PLL in use is locked.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module pll_clock_and_dac_calibration #(
	parameter int DAC_CAL_CYCLES = pll_cal_pkg::DAC_CAL_CYCLES,
	parameter int OSC_CAL_CYCLES = pll_cal_pkg::OSC_CAL_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire pll_cal_pkg::wb_req_t wb_req,
	output pll_cal_pkg::wb_rsp_t wb_rsp,
	input wire logic pll_lock_raw,
	input wire logic sync_clock_in,
	output logic clock_source_pll,
	output logic [8:0] pll_multiply_ratio,
	output logic [2:0] charge_pump_current_code,
	output logic [9:0] charge_pump_microamps,
	output logic oscillator_cal_active,
	output logic converter_cal_active,
	output logic irq
);
	import pll_cal_pkg::*;

	typedef struct packed {
		logic [31:0] first_reg;
		logic [31:0] third_reg;
		logic [31:0] fourth_reg;
		logic osc_req_prev;
		logic dac_req_prev;
		logic sync_prev;
		logic locked;
		logic [2:0] auto_cp;
		dac_state_t dac_fsm;
		logic [3:0] sync_cnt;
		logic [19:0] base_cnt;
		logic [3:0] irq_status;
		logic [3:0] irq_enable;
		logic ack;
		logic [31:0] rdata;
	} ctl_state_t;

	localparam ctl_state_t CTL_RESET = '{
		first_reg: FIRST_RESET,
		third_reg: THIRD_RESET,
		fourth_reg: FOURTH_RESET,
		osc_req_prev: 1'b0,
		dac_req_prev: 1'b0,
		sync_prev: 1'b0,
		locked: 1'b0,
		auto_cp: 3'h3,
		dac_fsm: DAC_IDLE,
		sync_cnt: 4'h0,
		base_cnt: 20'h00000,
		irq_status: 4'h0,
		irq_enable: 4'h0,
		ack: 1'b0,
		rdata: 32'h0000_0000
	};

	// Byte-lane merge of a bus write into a register image.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] sel, input logic [31:0] wmask);
		logic [31:0] lane;
		lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
		return (old_val & ~lane) | (new_val & lane);
	endfunction : merge_bytes

	// Charge-pump code that calibration settles on for a feedback divide value.
	function automatic logic [2:0] cp_for_divide(input logic [7:0] n);
		if (n < 8'h10)
			return 3'h0;
		else if (n < 8'h18)
			return 3'h1;
		else if (n < 8'h24)
			return 3'h2;
		else if (n < 8'h2C)
			return 3'h3;
		else if (n < 8'h38)
			return 3'h4;
		else if (n < 8'h40)
			return 3'h5;
		else if (n < 8'h50)
			return 3'h6;
		else
			return 3'h7;
	endfunction : cp_for_divide

	ctl_state_t st_q;
	ctl_state_t st_d;

	logic take;
	logic [5:0] widx;
	logic [31:0] rd;
	logic [3:0] events;
	logic [3:0] clear_bits;
	logic pll_en;
	logic manual_cp;
	logic [7:0] fb_divide;
	logic [2:0] prog_cp;
	logic sync_en;
	logic osc_rise;
	logic dac_rise;
	logic sync_edge;
	logic osc_start;
	logic dac_start;
	logic osc_busy;
	logic osc_done;
	logic dac_busy;
	logic dac_done;

	assign pll_en = st_q.third_reg[PLL_EN_BIT];
	assign manual_cp = st_q.third_reg[MANUAL_CP_BIT];
	assign fb_divide = st_q.third_reg[DIV_LSB +: 8];
	assign prog_cp = st_q.third_reg[CP_LSB +: 3];
	assign sync_en = st_q.fourth_reg[SYNC_EN_BIT];

	// Bus decode sits outside the state process so read data never feeds back into it.
	assign take = wb_req.cyc & wb_req.stb & ~st_q.ack;
	assign widx = wb_req.adr[7:2];

	// Runs start only on a request edge, so a held request never restarts one.
	assign osc_rise = st_q.first_reg[OSC_REQ_BIT] & ~st_q.osc_req_prev;
	assign dac_rise = st_q.fourth_reg[DAC_REQ_BIT] & ~st_q.dac_req_prev;
	assign osc_start = osc_rise & ~osc_busy;
	assign dac_start = dac_rise & (st_q.dac_fsm == DAC_IDLE);
	assign sync_edge = sync_clock_in & ~st_q.sync_prev;

	cal_timer osc_timer (
		.clock(clock),
		.arst_n(arst_n),
		.start(osc_start),
		.load(20'(OSC_CAL_CYCLES)),
		.busy(osc_busy),
		.done(osc_done)
	);

	cal_timer dac_timer (
		.clock(clock),
		.arst_n(arst_n),
		.start(dac_start),
		.load(20'(DAC_CAL_CYCLES)),
		.busy(dac_busy),
		.done(dac_done)
	);

	always_comb
	begin
		case (widx)
			IDX_FIRST: rd = st_q.first_reg;
			IDX_THIRD: rd = st_q.third_reg;
			IDX_FOURTH: rd = st_q.fourth_reg;
			IDX_LOCK:
			begin
				rd = 32'h0000_0000;
				rd[LOCK_BIT] = st_q.locked;
				rd[OSC_BUSY_BIT] = osc_busy;
				rd[DAC_BUSY_BIT] = converter_cal_active;
			end
			IDX_IRQ_STATUS: rd = {28'h0000000, st_q.irq_status};
			IDX_IRQ_ENABLE: rd = {28'h0000000, st_q.irq_enable};
			default: rd = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		st_d = st_q;
		clear_bits = 4'h0;
		events = 4'h0;
		st_d.ack = take;
		if (take && !wb_req.we)
			st_d.rdata = rd;
		if (take && wb_req.we)
		begin
			case (widx)
				IDX_FIRST: st_d.first_reg = merge_bytes(st_q.first_reg, wb_req.dat,
					wb_req.sel, FIRST_WMASK);
				IDX_THIRD: st_d.third_reg = merge_bytes(st_q.third_reg, wb_req.dat,
					wb_req.sel, THIRD_WMASK);
				IDX_FOURTH: st_d.fourth_reg = merge_bytes(st_q.fourth_reg, wb_req.dat,
					wb_req.sel, FOURTH_WMASK);
				IDX_IRQ_ENABLE:
					if (wb_req.sel[0])
						st_d.irq_enable = wb_req.dat[3:0];
				IDX_IRQ_CLEAR:
					if (wb_req.sel[0])
						clear_bits = wb_req.dat[3:0];
				default: ;
			endcase
		end
		st_d.osc_req_prev = st_q.first_reg[OSC_REQ_BIT];
		st_d.dac_req_prev = st_q.fourth_reg[DAC_REQ_BIT];
		st_d.sync_prev = sync_clock_in;

		// Calibration latches the automatic current for the programmed divide value.
		if (osc_done)
		begin
			st_d.auto_cp = cp_for_divide(fb_divide);
			events[EV_OSC_DONE] = 1'b1;
		end

		unique case (st_q.dac_fsm)
			DAC_IDLE:
			begin
				st_d.base_cnt = 20'h00000;
				if (dac_start)
					st_d.dac_fsm = DAC_BASE;
			end
			DAC_BASE:
			begin
				st_d.base_cnt = st_q.base_cnt + 20'h00001;
				st_d.sync_cnt = 4'h0;
				if (dac_done)
				begin
					if (sync_en)
						st_d.dac_fsm = DAC_SYNC;
					else
					begin
						st_d.dac_fsm = DAC_IDLE;
						events[EV_DAC_DONE] = 1'b1;
					end
				end
			end
			DAC_SYNC:
			begin
				// The extra time is counted in sync input periods, one per rising edge.
				if (sync_edge)
				begin
					if (st_q.sync_cnt == SYNC_LAST_EDGE)
					begin
						st_d.dac_fsm = DAC_IDLE;
						events[EV_DAC_DONE] = 1'b1;
					end
					else
						st_d.sync_cnt = st_q.sync_cnt + 4'h1;
				end
			end
		endcase

		// Lock only means something while the PLL is the clock source.
		st_d.locked = pll_lock_raw & pll_en;
		events[EV_LOCK_GAIN] = st_d.locked & ~st_q.locked;
		events[EV_LOCK_LOSS] = ~st_d.locked & st_q.locked;

		// A new event wins over a clear in the same cycle.
		st_d.irq_status = (st_q.irq_status & ~clear_bits) | events;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= CTL_RESET;
		else
			st_q <= st_d;
	end

	assign wb_rsp.ack = st_q.ack;
	assign wb_rsp.dat = st_q.rdata;
	assign clock_source_pll = pll_en;
	assign pll_multiply_ratio = {fb_divide, 1'b0};
	assign charge_pump_current_code = manual_cp ? prog_cp : st_q.auto_cp;
	assign charge_pump_microamps = (10'(charge_pump_current_code) + 10'h001) * CP_STEP_UA;
	assign oscillator_cal_active = osc_busy;
	assign converter_cal_active = st_q.dac_fsm != DAC_IDLE;
	assign irq = |(st_q.irq_status & st_q.irq_enable);

	// Assertions compare the sequencing against the register image and the timers.
	a_clock_select: assert property (@(posedge clock) disable iff (!arst_n)
		clock_source_pll == st_q.third_reg[PLL_EN_BIT])
		else $error("clock source does not follow PLL enable");
	a_ratio_even: assert property (@(posedge clock) disable iff (!arst_n)
		pll_multiply_ratio == 9'(2 * st_q.third_reg[DIV_LSB +: 8]))
		else $error("multiplication ratio is not twice the divide value");
	a_cp_manual: assert property (@(posedge clock) disable iff (!arst_n)
		manual_cp |-> charge_pump_current_code == st_q.third_reg[CP_LSB +: 3])
		else $error("manual charge-pump code not applied");
	a_cp_auto_kept: assert property (@(posedge clock) disable iff (!arst_n)
		(!manual_cp && !osc_done) |=> (manual_cp || $stable(st_q.auto_cp)))
		else $error("automatic charge-pump code changed without calibration");
	a_cp_from_div: assert property (@(posedge clock) disable iff (!arst_n)
		osc_done |=> st_q.auto_cp == cp_for_divide($past(fb_divide)))
		else $error("calibrated charge-pump code does not match divide value");
	a_osc_edge_start: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(osc_busy) |-> $past(osc_rise))
		else $error("oscillator calibration began without a request edge");
	a_dac_length: assert property (@(posedge clock) disable iff (!arst_n)
		(st_q.dac_fsm == DAC_BASE && dac_done) |-> st_q.base_cnt == 20'(DAC_CAL_CYCLES))
		else $error("converter calibration base length wrong");
	a_dac_timer_busy: assert property (@(posedge clock) disable iff (!arst_n)
		(st_q.dac_fsm == DAC_BASE && !dac_done) |-> dac_busy)
		else $error("converter timer idle during the base run");
	a_dac_idle_quiet: assert property (@(posedge clock) disable iff (!arst_n)
		(st_q.dac_fsm == DAC_IDLE && !dac_start) |=> st_q.dac_fsm == DAC_IDLE)
		else $error("converter calibration began without a request edge");
	a_sync_extra: assert property (@(posedge clock) disable iff (!arst_n)
		(st_q.dac_fsm == DAC_SYNC && st_d.dac_fsm == DAC_IDLE)
		|-> (sync_edge && st_q.sync_cnt == SYNC_LAST_EDGE))
		else $error("sync extension did not span sixteen sync periods");
	a_dac_no_restart: assert property (@(posedge clock) disable iff (!arst_n)
		(st_q.dac_fsm == DAC_BASE && !dac_done) |=> st_q.dac_fsm == DAC_BASE
		&& st_q.base_cnt == $past(st_q.base_cnt) + 20'h00001)
		else $error("converter calibration restarted or ended early");
	a_lock_gated: assert property (@(posedge clock) disable iff (!arst_n)
		st_q.locked |-> $past(pll_lock_raw) && $past(pll_en))
		else $error("lock reported without PLL in use and locked");
	a_irq_level: assert property (@(posedge clock) disable iff (!arst_n)
		irq == |(st_q.irq_status & st_q.irq_enable))
		else $error("interrupt output does not match enabled status");
	a_set_beats_clear: assert property (@(posedge clock) disable iff (!arst_n)
		(|events) |=> (st_q.irq_status & $past(events)) == $past(events))
		else $error("event lost against a status clear");

	c_osc_done: cover property (@(posedge clock) disable iff (!arst_n) osc_done);
	c_dac_sync: cover property (@(posedge clock) disable iff (!arst_n)
		st_q.dac_fsm == DAC_SYNC ##1 st_q.dac_fsm == DAC_IDLE);
	c_lock_read: cover property (@(posedge clock) disable iff (!arst_n)
		take && !wb_req.we && widx == IDX_LOCK && st_q.locked);
	c_dac_plain: cover property (@(posedge clock) disable iff (!arst_n)
		st_q.dac_fsm == DAC_BASE && dac_done && !sync_en);
	c_irq_raised: cover property (@(posedge clock) disable iff (!arst_n)
		$rose(irq));
endmodule : pll_clock_and_dac_calibration
`default_nettype wire

// ===== bench/ref_source_model.sv
// Model of the reference source: lock detector level and sync input clock.
`timescale 1ns/10ps
`default_nettype none
module ref_source_model (
	input wire logic clock,
	input wire logic lock_want,
	input wire logic sync_run,
	output logic pll_lock_raw,
	output var logic sync_clock_in
);
	logic [2:0] lock_cnt_q = 3'h0;
	logic [1:0] div_q = 2'h0;
	logic sync_q = 1'b0;
	// Lock comes some cycles after the reference settles and drops at once.
	always @(posedge clock)
	begin
		if (!lock_want)
			lock_cnt_q <= 3'h0;
		else if (lock_cnt_q != 3'h7)
			lock_cnt_q <= lock_cnt_q + 3'h1;
		// The sync clock stands still at low outside a run, period six clocks within.
		if (!sync_run)
		begin
			div_q <= 2'h0;
			sync_q <= 1'b0;
		end
		else
		begin
			div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
			if (div_q == 2'h2)
				sync_q <= !sync_q;
		end
	end
	assign pll_lock_raw = (lock_cnt_q == 3'h7);
	assign sync_clock_in = sync_q;
endmodule : ref_source_model
`default_nettype wire

// ===== bench/tb_pll_clock_and_dac_calibration.sv
// Testbench for the clock control and calibration block.
`timescale 1ns/10ps
`default_nettype none
module tb_pll_clock_and_dac_calibration;
	import pll_cal_pkg::*;
	localparam int DAC_N = 20;
	localparam int OSC_N = 8;
	logic clock;
	logic arst_n;
	wb_req_t req;
	wb_rsp_t rsp;
	logic lock_raw, sync_in, lock_want, sync_run, src_pll, osc_act, conv_act, irq;
	logic [8:0] ratio;
	logic [2:0] cp_code;
	logic [9:0] cp_ua;
	int num_errors = 0;
	int num_checks = 0;
	int len;
	pll_clock_and_dac_calibration #(.DAC_CAL_CYCLES(DAC_N), .OSC_CAL_CYCLES(OSC_N)) dut_u (
		.clock(clock), .arst_n(arst_n), .wb_req(req), .wb_rsp(rsp),
		.pll_lock_raw(lock_raw), .sync_clock_in(sync_in), .clock_source_pll(src_pll),
		.pll_multiply_ratio(ratio), .charge_pump_current_code(cp_code),
		.charge_pump_microamps(cp_ua), .oscillator_cal_active(osc_act),
		.converter_cal_active(conv_act), .irq(irq));
	ref_source_model src_u (.clock(clock), .lock_want(lock_want), .sync_run(sync_run),
		.pll_lock_raw(lock_raw), .sync_clock_in(sync_in));
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task summarize();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle; the request holds until ack is sampled high.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clock);
		req.cyc <= 1'b1;
		req.stb <= 1'b1;
		req.we <= w;
		req.adr <= a;
		req.sel <= 4'hF;
		req.dat <= wd;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (rsp.ack !== 1'b1 && n < 20);
		if (n >= 20)
			num_errors++;
		rd = rsp.dat;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		req.we <= 1'b0;
	endtask : wb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		wb(1'b1, a, d, v);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		wb(1'b0, a, 32'h0000_0000, v);
		chk(v, e);
	endtask : rdc
	// Counts the cycles for which the chosen calibration stays active.
	task meas(input logic w, output int l);
		int n;
		n = 0;
		l = 0;
		while ((w ? conv_act : osc_act) !== 1'b1 && n < 100)
		begin
			@(posedge clock);
			n++;
		end
		while ((w ? conv_act : osc_act) === 1'b1 && l < 2000)
		begin
			@(posedge clock);
			l++;
		end
	endtask : meas
	initial
	begin
		repeat (5000) @(posedge clock);
		num_errors++;
		summarize();
	end
	initial
	begin
		arst_n = 1'b0;
		req = '0;
		lock_want = 1'b0;
		sync_run = 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk(ratio, 32'h0000_0032);
		chk(cp_ua, 32'h0000_01F4);
		chk(src_pll, 32'h0000_0000);
		rdc(8'h08, THIRD_RESET);
		rdc(8'h40, 32'h0000_0000);
		rdc(8'h78, 32'h0000_0000);
		wr(8'h74, 32'h0000_000F);
		wr(8'h08, 32'h0004_0A38);
		chk(src_pll, 32'h0000_0001);
		chk(ratio, 32'h0000_0014);
		chk(cp_code, 32'h0000_0003);
		lock_want <= 1'b1;
		repeat (12) @(posedge clock);
		rdc(8'h6C, 32'h0100_0000);
		rdc(8'h70, 32'h0000_0004);
		wr(8'h78, 32'h0000_000F);
		wr(8'h00, 32'h0100_0000);
		meas(1'b0, len);
		chk(len, OSC_N);
		rdc(8'h70, 32'h0000_0001);
		chk(irq, 32'h0000_0001);
		chk(cp_code, 32'h0000_0000);
		wr(8'h00, 32'h0100_0000);
		repeat (4) @(posedge clock);
		chk(osc_act, 32'h0000_0000);
		wr(8'h74, 32'h0000_0000);
		chk(irq, 32'h0000_0000);
		wr(8'h74, 32'h0000_000F);
		wr(8'h78, 32'h0000_000F);
		chk(irq, 32'h0000_0000);
		wr(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0100_0000);
		fork
			meas(1'b0, len);
			rdc(8'h6C, 32'h0100_0001);
		join
		chk(len, OSC_N);
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h08, 32'h0004_0A40 | (c << 3));
			chk(cp_code, c);
			chk(cp_ua, (c + 1) * 125);
		end
		wr(8'h08, 32'h0004_0A38);
		chk(cp_code, 32'h0000_0000);
		wr(8'h08, 32'h0004_FF00);
		chk(ratio, 32'h0000_01FE);
		wr(8'h78, 32'h0000_000F);
		lock_want <= 1'b0;
		repeat (3) @(posedge clock);
		rdc(8'h6C, 32'h0000_0000);
		rdc(8'h70, 32'h0000_0008);
		lock_want <= 1'b1;
		wr(8'h08, 32'h0000_0A00);
		chk(src_pll, 32'h0000_0000);
		repeat (12) @(posedge clock);
		rdc(8'h6C, 32'h0000_0000);
		wr(8'h78, 32'h0000_000F);
		wr(8'h0C, 32'h0100_0000);
		fork
			meas(1'b1, len);
			begin
				wr(8'h0C, 32'h0000_0000);
				rdc(8'h6C, 32'h0000_0002);
			end
		join
		chk(len, DAC_N + 1);
		rdc(8'h70, 32'h0000_0002);
		sync_run <= 1'b1;
		wr(8'h0C, 32'h0300_0000);
		fork
			meas(1'b1, len);
			begin
				wr(8'h0C, 32'h0200_0000);
				wr(8'h0C, 32'h0300_0000);
			end
		join
		chk(len >= DAC_N + 91 && len <= DAC_N + 99, 32'h0000_0001);
		summarize();
	end
endmodule : tb_pll_clock_and_dac_calibration
`default_nettype wire
